// ---- core/scra_consts.svh ----
// scra_consts.svh: offsets, field positions, reset values and timing counts
// assumes: included by its bare name wherever a figure is needed
`ifndef SCRA_CONSTS_SVH
`define SCRA_CONSTS_SVH

// ==========================================
// link byte codes
`define SCRA_DEV_ADDR          6'h07
`define SCRA_XFER_WRITE        2'h2
`define SCRA_XFER_READ         2'h3
`define SCRA_FLAG_WRITE        1'h0
`define SCRA_FLAG_PREP_READ    1'h1

// ==========================================
// device register offsets
`define SCRA_REG_SYSTEM_CONFIG 7'h00
`define SCRA_REG_MASTER_VOLUME 7'h11
`define SCRA_REG_SILENCE_OUT   7'h12
`define SCRA_REG_ADC_MIX_VOL   7'h13
`define SCRA_REG_MUTE_DEEMPH   7'h14
`define SCRA_REG_INTERP_STATUS 7'h18
`define SCRA_REG_ADC_CONFIG    7'h20
`define SCRA_REG_SOFT_RESET    7'h7f

// ==========================================
// device reset values
`define SCRA_RST_SYSTEM_CONFIG 16'h0b40
`define SCRA_RST_MASTER_VOLUME 16'h0000
`define SCRA_RST_SILENCE_OUT   16'h0001
`define SCRA_RST_ADC_MIX_VOL   16'h0000
`define SCRA_RST_MUTE_DEEMPH   16'h0000
`define SCRA_RST_ADC_CONFIG    16'he000

// ==========================================
// system_config upper byte fields
`define SCRA_SYS_DAC_POL_INV   13
`define SCRA_SYS_ADC_POL_INV   12
`define SCRA_SYS_DAC_PON       11
`define SCRA_SYS_SC_HI         9
`define SCRA_SYS_SC_LO         8

// ==========================================
// controller register map (byte addresses)
`define SCRA_HOST_REG_ADDR     5'h00
`define SCRA_HOST_REG_WDATA    5'h04
`define SCRA_HOST_REG_CMD      5'h08
`define SCRA_HOST_REG_STATUS   5'h0c
`define SCRA_HOST_REG_RDATA    5'h10
`define SCRA_OP_WRITE          2'h0
`define SCRA_OP_PREP_READ      2'h1
`define SCRA_OP_READ           2'h2

// ==========================================
// timing
`define SCRA_SYS_CLK_NS        10
`define SCRA_LINK_HALF_NS      80
`define SCRA_LINK_HALF_CYC     (`SCRA_LINK_HALF_NS / `SCRA_SYS_CLK_NS)
`define SCRA_WR_RD_GAP_NS      8000
`define SCRA_WR_RD_GAP_CYC     ((`SCRA_WR_RD_GAP_NS + `SCRA_SYS_CLK_NS - 1) / `SCRA_SYS_CLK_NS)

`endif

// ---- core/scra_pkg.sv ----
// scra_pkg: state types of both link ends
// assumes: nothing
package scra_pkg;

	typedef logic [15:0] scra_word_t;

	typedef enum logic [2:0] {DV_SLEEP, DV_ADDR, DV_REG, DV_WDATA, DV_RDATA, DV_SKIP} scra_dev_st_e;

	typedef enum logic [2:0] {HS_WAKE_LO, HS_WAKE_HI, HS_IDLE, HS_LO, HS_HI, HS_GAP} scra_host_st_e;

	typedef struct packed {
		scra_dev_st_e    st;
		logic            clk_q;
		logic            mode_q;
		logic [2:0]      bit_cnt;
		logic [1:0]      byte_idx;
		logic [7:0]      shift;
		logic [7:0]      tx;
		logic            oe;
		logic [6:0]      wr_addr;
		logic [6:0]      rd_addr;
		logic [7:0]      msb_hold;
		scra_word_t [5:0] regs;
	} scra_dev_s;

	typedef struct packed {
		scra_host_st_e st;
		logic [3:0]    div;
		logic [9:0]    gap;
		logic          go;
		logic          fin;
		logic [1:0]    op;
		logic [1:0]    byte_idx;
		logic [2:0]    bit_cnt;
		logic [7:0]    tx;
		logic [7:0]    rx;
		logic          clk;
		logic          mode;
		logic          data_o;
		logic          data_oe;
		logic [6:0]    reg_addr;
		scra_word_t    wdata;
		scra_word_t    rdata;
		logic          invalid;
		logic          rd_ack;
		logic [31:0]   readdata;
	} scra_host_s;

endpackage : scra_pkg

// ---- core/scra_if.sv ----
// scra_if: three-wire control link between controller and device
// assumes: data line pulled high when nobody drives it
`timescale 1ns/1ps
interface scra_if;
	logic ctl_clock_line;
	logic ctl_mode_line;
	logic host_data_o;
	logic host_data_oe;
	logic dev_data_o;
	logic dev_data_oe;
	logic ctl_data_line;

	assign ctl_data_line = dev_data_oe ? dev_data_o : (host_data_oe ? host_data_o : 1'b1);

	modport host (
		output ctl_clock_line,
		output ctl_mode_line,
		output host_data_o,
		output host_data_oe,
		input  ctl_data_line
	);

	modport dev (
		input  ctl_clock_line,
		input  ctl_mode_line,
		input  ctl_data_line,
		output dev_data_o,
		output dev_data_oe
	);
endinterface : scra_if

// ---- core/scra_sync.sv ----
// scra_sync: two-flop synchroniser for pin inputs
// assumes: inputs are levels from outside i_clk_sys
`timescale 1ns/1ps
module scra_sync #(
	parameter int W = 1
) (
	input  wire logic         i_clk_sys,
	input  wire logic         i_rst,
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);
	logic [W-1:0] meta_reg;

	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
		begin
			meta_reg <= '0;
			o_q      <= '0;
		end
		else
		begin
			meta_reg <= i_d;
			o_q      <= meta_reg;
		end
	end
endmodule : scra_sync

// ---- core/scra_device.sv ----
// scra_device: device end of the control link with its register file
// assumes: controller makes the link clock; pins sampled on i_clk_sys
`timescale 1ns/1ps
`include "scra_consts.svh"

// Overview of operation
// - register byte: direction flag, seven address bits
// - write flag first bit zero
// - prepare-read flag one latches read address
// - read reply address byte, flag marks invalid
// - write is address, register, two data
// - new register needs new device address
// - first clock pulse only wakes interface
// - read code makes device drive data
// - reply data two bytes, high first
// - read waits 8 us after write
// - reads and writes in any order
// - sixteen-bit registers, upper byte fields defaulted
// - bytes travel lowest bit first
// - mode low, eight pulses address device
// - address bits 7..2 device, 1..0 type
module scra_device
	import scra_pkg::*;
(
	input  wire logic       i_clk_sys,
	input  wire logic       i_rst,
	scra_if.dev             link,
	input  wire scra_word_t i_interpolator_status,
	output scra_word_t      o_system_config,
	output scra_word_t      o_master_volume,
	output scra_word_t      o_silence_and_output_select,
	output scra_word_t      o_adc_and_mixer_volume,
	output scra_word_t      o_mute_and_deemphasis,
	output scra_word_t      o_adc_config,
	output logic            o_dac_polarity_invert,
	output logic            o_adc_polarity_invert,
	output logic            o_dac_power_on,
	output logic            o_sysclk_ratio_sel_hi,
	output logic            o_sysclk_ratio_sel_lo
);
	localparam scra_word_t [5:0] DEF = {
		`SCRA_RST_ADC_CONFIG, `SCRA_RST_MUTE_DEEMPH, `SCRA_RST_ADC_MIX_VOL,
		`SCRA_RST_SILENCE_OUT, `SCRA_RST_MASTER_VOLUME, `SCRA_RST_SYSTEM_CONFIG};
	localparam logic [2:0] NO_IDX = 3'h7;

	// ==========================================
	// pin synchronisers
	logic [2:0] pins_s;
	logic       s_clk_n;
	logic       s_clk;
	logic       s_mode;
	logic       s_data;

	scra_sync #(.W(3)) u_sync (
		.i_clk_sys (i_clk_sys),
		.i_rst     (i_rst),
		.i_d       ({~link.ctl_clock_line, link.ctl_mode_line, link.ctl_data_line}),
		.o_q       (pins_s)
	);
	// clock enters inverted: a cleared synchroniser reads the idle-high level, no false rise
	assign {s_clk_n, s_mode, s_data} = pins_s;
	assign s_clk = ~s_clk_n;

	// ==========================================
	// register map helpers
	function automatic logic [2:0] reg_idx(input logic [6:0] a);
		logic [2:0] i;
		i = NO_IDX;
		unique case (a)
			`SCRA_REG_SYSTEM_CONFIG: i = 3'h0;
			`SCRA_REG_MASTER_VOLUME: i = 3'h1;
			`SCRA_REG_SILENCE_OUT:   i = 3'h2;
			`SCRA_REG_ADC_MIX_VOL:   i = 3'h3;
			`SCRA_REG_MUTE_DEEMPH:   i = 3'h4;
			`SCRA_REG_ADC_CONFIG:    i = 3'h5;
			default:                 i = NO_IDX;
		endcase
		return i;
	endfunction : reg_idx

	// reversed address order: A6 rides first after the flag
	function automatic logic [6:0] rev7(input logic [6:0] a);
		return {a[0], a[1], a[2], a[3], a[4], a[5], a[6]};
	endfunction : rev7

	scra_dev_s  r_reg;
	scra_dev_s  r_next;
	logic       rise;
	logic       mode_chg;
	logic       last_bit;
	logic [7:0] nb;
	logic       rd_valid;
	scra_word_t rd_word;

	always_comb
	begin
		rd_word  = 16'h0000;
		rd_valid = 1'b0;
		if (r_reg.rd_addr == `SCRA_REG_INTERP_STATUS)
		begin
			rd_valid = 1'b1;
			rd_word  = i_interpolator_status;
		end
		else if (reg_idx(r_reg.rd_addr) != NO_IDX)
		begin
			rd_valid = 1'b1;
			rd_word  = r_reg.regs[reg_idx(r_reg.rd_addr)];
		end
	end

	// ==========================================
	// link state machine
	always_comb
	begin
		r_next        = r_reg;
		r_next.clk_q  = s_clk;
		r_next.mode_q = s_mode;
		rise          = s_clk & ~r_reg.clk_q;
		mode_chg      = s_mode ^ r_reg.mode_q;
		last_bit      = (r_reg.bit_cnt == 3'h7);
		nb            = {s_data, r_reg.shift[7:1]};
		if (mode_chg && r_reg.st != DV_SLEEP)
		begin
			r_next.bit_cnt  = 3'h0;
			r_next.byte_idx = 2'h0;
			if (!s_mode)
			begin
				r_next.st = DV_ADDR;
				r_next.oe = 1'b0;
			end
			else if (r_reg.st == DV_RDATA)
				r_next.oe = 1'b1;
		end
		else if (rise)
		begin
			r_next.shift   = nb;
			r_next.bit_cnt = r_reg.bit_cnt + 3'h1;
			unique case (r_reg.st)
				DV_SLEEP:
				begin
					r_next.st      = DV_ADDR;
					r_next.bit_cnt = 3'h0;
				end
				DV_ADDR:
					if (last_bit)
					begin
						r_next.st = DV_SKIP;
						if (nb[7:2] == `SCRA_DEV_ADDR)
						begin
							if (nb[1:0] == `SCRA_XFER_WRITE)
								r_next.st = DV_REG;
							else if (nb[1:0] == `SCRA_XFER_READ)
							begin
								r_next.st = DV_RDATA;
								r_next.tx = {rev7(r_reg.rd_addr), ~rd_valid};
							end
						end
					end
				DV_REG:
					if (last_bit)
					begin
						// any mix of writes and prepare-reads is taken
						if (nb[0] == `SCRA_FLAG_WRITE)
						begin
							r_next.wr_addr = rev7(nb[7:1]);
							r_next.st      = DV_WDATA;
						end
						else
						begin
							r_next.rd_addr = rev7(nb[7:1]);
							r_next.st      = DV_SKIP;
						end
					end
				DV_WDATA:
					if (last_bit)
					begin
						r_next.byte_idx = r_reg.byte_idx + 2'h1;
						if (r_reg.byte_idx == 2'h0)
							r_next.msb_hold = nb;
						else
						begin
							r_next.st = DV_SKIP;
							if (r_reg.wr_addr == `SCRA_REG_SOFT_RESET)
								r_next.regs = DEF;
							else if (reg_idx(r_reg.wr_addr) != NO_IDX)
								r_next.regs[reg_idx(r_reg.wr_addr)] = {r_reg.msb_hold, nb};
						end
					end
				DV_RDATA:
				begin
					r_next.tx = {1'b0, r_reg.tx[7:1]};
					if (last_bit)
					begin
						r_next.byte_idx = r_reg.byte_idx + 2'h1;
						unique case (r_reg.byte_idx)
							2'h0:    r_next.tx = rd_word[15:8];
							2'h1:    r_next.tx = rd_word[7:0];
							default:
							begin
								r_next.oe = 1'b0;
								r_next.st = DV_SKIP;
							end
						endcase
					end
				end
				DV_SKIP:
					r_next.st = DV_SKIP;
			endcase
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
			r_reg <= '{st: DV_SLEEP, clk_q: 1'b1, regs: DEF, default: '0};
		else
			r_reg <= r_next;
	end

	// ==========================================
	// outputs
	assign link.dev_data_o              = r_reg.tx[0];
	assign link.dev_data_oe             = r_reg.oe;
	assign o_system_config              = r_reg.regs[0];
	assign o_master_volume              = r_reg.regs[1];
	assign o_silence_and_output_select  = r_reg.regs[2];
	assign o_adc_and_mixer_volume       = r_reg.regs[3];
	assign o_mute_and_deemphasis        = r_reg.regs[4];
	assign o_adc_config                 = r_reg.regs[5];
	assign o_dac_polarity_invert        = r_reg.regs[0][`SCRA_SYS_DAC_POL_INV];
	assign o_adc_polarity_invert        = r_reg.regs[0][`SCRA_SYS_ADC_POL_INV];
	assign o_dac_power_on               = r_reg.regs[0][`SCRA_SYS_DAC_PON];
	assign o_sysclk_ratio_sel_hi        = r_reg.regs[0][`SCRA_SYS_SC_HI];
	assign o_sysclk_ratio_sel_lo        = r_reg.regs[0][`SCRA_SYS_SC_LO];
endmodule : scra_device

// ---- core/scra_host.sv ----
// scra_host: controller end; software orders transfers over Avalon-MM
// assumes: device end joined through scra_if; link clock made here
`timescale 1ns/1ps
`include "scra_consts.svh"
module scra_host
	import scra_pkg::*;
(
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst,
	scra_if.host             link,
	input  wire logic [4:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	output logic [31:0]      o_avs_readdata,
	output logic             o_avs_waitrequest
);
	localparam logic [3:0] HALF = 4'(`SCRA_LINK_HALF_CYC);
	localparam logic [9:0] GAP  = 10'(`SCRA_WR_RD_GAP_CYC);

	logic s_data;

	scra_sync #(.W(1)) u_sync (
		.i_clk_sys (i_clk_sys),
		.i_rst     (i_rst),
		.i_d       (link.ctl_data_line),
		.o_q       (s_data)
	);

	scra_host_s r_reg;
	scra_host_s r_next;
	logic       busy;
	logic       half_done;
	logic [1:0] last_idx;
	logic [7:0] byte_out;
	logic [1:0] nxt_idx;

	// byte k of the current transfer, lowest bit sent first
	always_comb
	begin
		nxt_idx  = (r_reg.st == HS_IDLE) ? 2'h0 : r_reg.byte_idx + 2'h1;
		byte_out = 8'h00;
		unique case (nxt_idx)
			2'h0: byte_out = {`SCRA_DEV_ADDR, (r_reg.op == `SCRA_OP_READ) ? `SCRA_XFER_READ : `SCRA_XFER_WRITE};
			2'h1: byte_out = {r_reg.reg_addr[0], r_reg.reg_addr[1], r_reg.reg_addr[2], r_reg.reg_addr[3],
				r_reg.reg_addr[4], r_reg.reg_addr[5], r_reg.reg_addr[6],
				(r_reg.op == `SCRA_OP_PREP_READ) ? `SCRA_FLAG_PREP_READ : `SCRA_FLAG_WRITE};
			2'h2: byte_out = r_reg.wdata[15:8];
			2'h3: byte_out = r_reg.wdata[7:0];
		endcase
	end

	// ==========================================
	// bus slave and link sequencer
	always_comb
	begin
		r_next            = r_reg;
		busy              = (r_reg.st != HS_IDLE) | r_reg.go;
		o_avs_waitrequest = (i_avs_read & ~r_reg.rd_ack)
			| (i_avs_write & (i_avs_address == `SCRA_HOST_REG_CMD) & busy);
		half_done         = (r_reg.div == HALF - 4'h1);
		last_idx          = (r_reg.op == `SCRA_OP_PREP_READ) ? 2'h1 : 2'h3;
		r_next.div        = half_done ? 4'h0 : r_reg.div + 4'h1;
		r_next.rd_ack     = i_avs_read & ~r_reg.rd_ack;
		if (r_reg.gap != 10'h000)
			r_next.gap = r_reg.gap - 10'h001;
		if (i_avs_read & ~r_reg.rd_ack)
		begin
			unique case (i_avs_address)
				`SCRA_HOST_REG_ADDR:   r_next.readdata = {25'h0, r_reg.reg_addr};
				`SCRA_HOST_REG_WDATA:  r_next.readdata = {16'h0, r_reg.wdata};
				`SCRA_HOST_REG_STATUS: r_next.readdata = {29'h0, r_reg.gap != 10'h000, r_reg.invalid, busy};
				`SCRA_HOST_REG_RDATA:  r_next.readdata = {16'h0, r_reg.rdata};
				default:               r_next.readdata = 32'h0;
			endcase
		end
		if (i_avs_write & ~o_avs_waitrequest)
		begin
			unique case (i_avs_address)
				`SCRA_HOST_REG_ADDR:  r_next.reg_addr = i_avs_writedata[6:0];
				`SCRA_HOST_REG_WDATA: r_next.wdata    = i_avs_writedata[15:0];
				`SCRA_HOST_REG_CMD:
				begin
					r_next.op = i_avs_writedata[1:0];
					r_next.go = 1'b1;
				end
				default: r_next.go = r_reg.go;
			endcase
		end
		unique case (r_reg.st)
			HS_WAKE_LO:
			begin
				r_next.clk = 1'b0;
				if (half_done)
					r_next.st = HS_WAKE_HI;
			end
			HS_WAKE_HI:
			begin
				r_next.clk = 1'b1;
				if (half_done)
					r_next.st = HS_IDLE;
			end
			HS_IDLE:
			begin
				r_next.div = 4'h0;
				if (r_reg.go && (r_reg.op != `SCRA_OP_READ || r_reg.gap == 10'h000))
				begin
					r_next.go       = 1'b0;
					r_next.fin      = 1'b0;
					r_next.byte_idx = 2'h0;
					r_next.bit_cnt  = 3'h0;
					r_next.mode     = 1'b0;
					r_next.tx       = byte_out;
					r_next.data_o   = byte_out[0];
					r_next.data_oe  = 1'b1;
					r_next.clk      = 1'b0;
					r_next.st       = HS_LO;
				end
			end
			HS_LO:
				if (half_done)
				begin
					r_next.clk = 1'b1;
					r_next.rx  = {s_data, r_reg.rx[7:1]};
					r_next.st  = HS_HI;
				end
			HS_HI:
				if (half_done)
				begin
					if (r_reg.bit_cnt != 3'h7)
					begin
						r_next.bit_cnt = r_reg.bit_cnt + 3'h1;
						r_next.tx      = {1'b0, r_reg.tx[7:1]};
						r_next.data_o  = r_reg.tx[1];
						r_next.clk     = 1'b0;
						r_next.st      = HS_LO;
					end
					else
					begin
						r_next.bit_cnt = 3'h0;
						r_next.st      = HS_GAP;
						if (r_reg.op == `SCRA_OP_READ)
						begin
							unique case (r_reg.byte_idx)
								2'h1:    r_next.invalid      = r_reg.rx[0];
								2'h2:    r_next.rdata[15:8] = r_reg.rx;
								2'h3:    r_next.rdata[7:0]  = r_reg.rx;
								default: r_next.invalid      = r_reg.invalid;
							endcase
						end
						if (r_reg.byte_idx == last_idx)
						begin
							r_next.fin     = 1'b1;
							r_next.mode    = 1'b0;
							r_next.data_oe = 1'b0;
							if (r_reg.op == `SCRA_OP_WRITE)
								r_next.gap = GAP;
						end
						else
						begin
							r_next.byte_idx = r_reg.byte_idx + 2'h1;
							r_next.mode     = 1'b1;
							r_next.tx       = byte_out;
							r_next.data_oe  = (r_reg.op != `SCRA_OP_READ);
						end
					end
				end
			HS_GAP:
				if (half_done)
				begin
					r_next.st  = r_reg.fin ? HS_IDLE : HS_LO;
					r_next.clk = r_reg.fin;
					// next byte's first bit goes out with the falling clock, never while high
					if (!r_reg.fin)
						r_next.data_o = r_reg.tx[0];
				end
		endcase
	end

	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
			r_reg <= '{st: HS_WAKE_LO, clk: 1'b1, default: '0};
		else
			r_reg <= r_next;
	end

	assign link.ctl_clock_line = r_reg.clk;
	assign link.ctl_mode_line  = r_reg.mode;
	assign link.host_data_o    = r_reg.data_o;
	assign link.host_data_oe   = r_reg.data_oe;
	assign o_avs_readdata      = r_reg.readdata;
endmodule : scra_host

// ---- bench/scra_properties.sv ----
// scra_properties: link-level checks between the two ends
// assumes: inputs taken straight from the scra_if instance
`timescale 1ns/1ps
module scra_properties (
	input  wire logic i_clk_sys,
	input  wire logic i_rst,
	input  wire logic ctl_clock_line,
	input  wire logic ctl_mode_line,
	input  wire logic ctl_data_line,
	input  wire logic host_data_o,
	input  wire logic host_data_oe,
	input  wire logic dev_data_o,
	input  wire logic dev_data_oe
);
	logic [4:0] rise_cnt_reg;

	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (i_rst);

	// ==========================================
	// link rises seen while the device drives
	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
			rise_cnt_reg <= 5'h00;
		else if (!dev_data_oe)
			rise_cnt_reg <= 5'h00;
		else if ($rose(ctl_clock_line))
			rise_cnt_reg <= rise_cnt_reg + 5'h01;
	end

	// ==========================================
	// properties
	property p_clk_low;
		$fell(ctl_clock_line) |-> !ctl_clock_line [*8] ##1 ctl_clock_line;
	endproperty
	a_clk_low: assert property (p_clk_low) else $error("link clock low time wrong");

	property p_clk_high;
		$rose(ctl_clock_line) |-> ctl_clock_line [*8];
	endproperty
	a_clk_high: assert property (p_clk_high) else $error("link clock high time short");

	property p_mode_on_high;
		$changed(ctl_mode_line) |-> $past(ctl_clock_line);
	endproperty
	a_mode_on_high: assert property (p_mode_on_high) else $error("mode moved with clock low");

	property p_host_hold;
		host_data_oe && $past(host_data_oe) && ctl_clock_line && $past(ctl_clock_line) |-> $stable(host_data_o);
	endproperty
	a_host_hold: assert property (p_host_hold) else $error("host bit moved while clock high");

	property p_one_driver;
		!(host_data_oe && dev_data_oe);
	endproperty
	a_one_driver: assert property (p_one_driver) else $error("both ends drive data");

	property p_dev_oe_start;
		$rose(dev_data_oe) |-> ctl_mode_line && !host_data_oe;
	endproperty
	a_dev_oe_start: assert property (p_dev_oe_start) else $error("device drove outside reply");

	property p_dev_release;
		$fell(ctl_mode_line) |-> ##[0:6] !dev_data_oe;
	endproperty
	a_dev_release: assert property (p_dev_release) else $error("device kept line after mode fell");

	property p_rise_max;
		rise_cnt_reg <= 5'h18;
	endproperty
	a_rise_max: assert property (p_rise_max) else $error("device drove past three bytes");

	property p_dev_oe_end;
		rise_cnt_reg == 5'h18 |-> ##[0:8] !dev_data_oe;
	endproperty
	a_dev_oe_end: assert property (p_dev_oe_end) else $error("device held line after reply");

	property p_dev_in_data;
		dev_data_oe |-> ctl_mode_line;
	endproperty
	a_dev_in_data: assert property (p_dev_in_data) else $error("device drove outside data mode");

	c_reply: cover property ($rose(dev_data_oe));
	c_full_reply: cover property (rise_cnt_reg == 5'h18);
	c_data_mode: cover property ($rose(ctl_mode_line));
endmodule : scra_properties

// ---- bench/serial_control_register_access_test.sv ----
// serial_control_register_access_test: host and device back to back, driven over Avalon-MM
// assumes: scra_consts.svh on the include path
`timescale 1ns/1ps
`include "scra_consts.svh"
module serial_control_register_access_test
	import scra_pkg::*;
;
	logic        i_clk_sys     = 1'b0;
	logic        i_rst         = 1'b1;
	logic [4:0]  avs_address   = 5'h00;
	logic        avs_read      = 1'b0;
	logic        avs_write     = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	scra_word_t  interp        = 16'h0000;
	scra_word_t  sys_cfg, mvol, sil, advol, mute, adcfg;
	logic        pol_dac, pol_adc, pon, sc_hi, sc_lo;
	scra_word_t  mdl [int];
	int          rw [6]        = '{`SCRA_REG_SYSTEM_CONFIG, `SCRA_REG_MASTER_VOLUME, `SCRA_REG_SILENCE_OUT,
	                               `SCRA_REG_ADC_MIX_VOL, `SCRA_REG_MUTE_DEEMPH, `SCRA_REG_ADC_CONFIG};
	int          mismatches    = 0;
	int          num_checks    = 0;
	logic [7:0]  addr_sh       = 8'h00;
	logic [31:0] rd;

	always #5 i_clk_sys = ~i_clk_sys;

	scra_if ifc ();
	scra_host u_scra_host (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .link(ifc), .i_avs_address(avs_address),
		.i_avs_read(avs_read), .i_avs_write(avs_write), .i_avs_writedata(avs_writedata),
		.o_avs_readdata(avs_readdata), .o_avs_waitrequest(avs_waitrequest));
	scra_device u_scra_device (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .link(ifc), .i_interpolator_status(interp),
		.o_system_config(sys_cfg), .o_master_volume(mvol), .o_silence_and_output_select(sil),
		.o_adc_and_mixer_volume(advol), .o_mute_and_deemphasis(mute), .o_adc_config(adcfg),
		.o_dac_polarity_invert(pol_dac), .o_adc_polarity_invert(pol_adc), .o_dac_power_on(pon),
		.o_sysclk_ratio_sel_hi(sc_hi), .o_sysclk_ratio_sel_lo(sc_lo));
	scra_properties u_scra_properties (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
		.ctl_clock_line(ifc.ctl_clock_line), .ctl_mode_line(ifc.ctl_mode_line), .ctl_data_line(ifc.ctl_data_line),
		.host_data_o(ifc.host_data_o), .host_data_oe(ifc.host_data_oe), .dev_data_o(ifc.dev_data_o),
		.dev_data_oe(ifc.dev_data_oe));

	// ==========================================
	// checking and closing
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic tally_and_finish();
		$display("checks=%0d mismatches=%0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : tally_and_finish

	// ==========================================
	// address byte seen on the wire, lowest bit first
	always @(posedge ifc.ctl_clock_line)
		if (!ifc.ctl_mode_line)
			addr_sh = {ifc.ctl_data_line, addr_sh[7:1]};
	always @(posedge ifc.ctl_mode_line)
	begin
		chk(addr_sh[7:2], `SCRA_DEV_ADDR);
		chk(addr_sh[1], 1'b1);
	end

	// ==========================================
	// bus cycles and model
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge i_clk_sys);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do
		begin
			@(posedge i_clk_sys);
			n++;
		end
		while (avs_waitrequest !== 1'b0 && n < 4000);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (n >= 4000)
		begin
			mismatches++;
			tally_and_finish();
		end
	endtask : bus

	task automatic wait_idle();
		int n;
		for (n = 0; n < 2000; n++)
		begin
			bus(1'b0, `SCRA_HOST_REG_STATUS, 32'h0);
			if (rd[0] === 1'b0)
				break;
		end
		if (n >= 2000)
		begin
			mismatches++;
			tally_and_finish();
		end
		repeat (8) @(posedge i_clk_sys);
	endtask : wait_idle

	task automatic reset_model();
		mdl[`SCRA_REG_SYSTEM_CONFIG] = `SCRA_RST_SYSTEM_CONFIG;
		mdl[`SCRA_REG_MASTER_VOLUME] = `SCRA_RST_MASTER_VOLUME;
		mdl[`SCRA_REG_SILENCE_OUT] = `SCRA_RST_SILENCE_OUT;
		mdl[`SCRA_REG_ADC_MIX_VOL] = `SCRA_RST_ADC_MIX_VOL;
		mdl[`SCRA_REG_MUTE_DEEMPH] = `SCRA_RST_MUTE_DEEMPH;
		mdl[`SCRA_REG_ADC_CONFIG] = `SCRA_RST_ADC_CONFIG;
	endtask : reset_model

	task automatic check_outs();
		scra_word_t s;
		s = mdl[`SCRA_REG_SYSTEM_CONFIG];
		chk(sys_cfg, s);
		chk(mvol, mdl[`SCRA_REG_MASTER_VOLUME]);
		chk(sil, mdl[`SCRA_REG_SILENCE_OUT]);
		chk(advol, mdl[`SCRA_REG_ADC_MIX_VOL]);
		chk(mute, mdl[`SCRA_REG_MUTE_DEEMPH]);
		chk(adcfg, mdl[`SCRA_REG_ADC_CONFIG]);
		chk({pol_dac, pol_adc, pon, sc_hi, sc_lo}, {s[13], s[12], s[11], s[9], s[8]});
	endtask : check_outs

	task automatic dev_write(input int a, input scra_word_t d);
		bus(1'b1, `SCRA_HOST_REG_ADDR, 32'(a));
		bus(1'b1, `SCRA_HOST_REG_WDATA, {16'h0, d});
		bus(1'b1, `SCRA_HOST_REG_CMD, 32'(`SCRA_OP_WRITE));
		wait_idle();
		if (a == `SCRA_REG_SOFT_RESET)
			reset_model();
		else if (mdl.exists(a))
			mdl[a] = d;
	endtask : dev_write

	task automatic dev_read(input int a);
		logic       ok;
		scra_word_t exp;
		ok = mdl.exists(a) || a == `SCRA_REG_INTERP_STATUS;
		exp = (a == `SCRA_REG_INTERP_STATUS) ? interp : (mdl.exists(a) ? mdl[a] : 16'h0000);
		bus(1'b1, `SCRA_HOST_REG_ADDR, 32'(a));
		bus(1'b1, `SCRA_HOST_REG_CMD, 32'(`SCRA_OP_PREP_READ));
		bus(1'b1, `SCRA_HOST_REG_CMD, 32'(`SCRA_OP_READ));
		wait_idle();
		bus(1'b0, `SCRA_HOST_REG_RDATA, 32'h0);
		chk(rd[15:0], exp);
		bus(1'b0, `SCRA_HOST_REG_STATUS, 32'h0);
		chk(rd[1], !ok);
	endtask : dev_read

	// ==========================================
	// main sequence
	initial
	begin
		void'($urandom(32'hf673210a));
		reset_model();
		repeat (3) @(posedge i_clk_sys);
		i_rst <= 1'b0;
		@(posedge i_clk_sys);
		check_outs();
		foreach (rw[i])
		begin
			dev_read(rw[i]);
			dev_write(rw[i], 16'($urandom));
			bus(1'b0, `SCRA_HOST_REG_STATUS, 32'h0);
			chk(rd[2], 1'b1);
			check_outs();
			dev_read(rw[i]);
		end
		@(posedge i_clk_sys);
		interp <= 16'($urandom);
		@(posedge i_clk_sys);
		dev_read(`SCRA_REG_INTERP_STATUS);
		dev_write(7'h05, 16'hffff);
		dev_read(7'h05);
		dev_read(`SCRA_REG_SOFT_RESET);
		dev_write(`SCRA_REG_SOFT_RESET, 16'($urandom));
		check_outs();
		dev_read(`SCRA_REG_SYSTEM_CONFIG);
		bus(1'b0, 5'h14, 32'h0);
		chk(rd, 32'h0);
		tally_and_finish();
	end
endmodule : serial_control_register_access_test
